// ===== verilog/nvcs_top.sv
// Nonvolatile memory configuration and security: clock divider,
// option mirror, security state, backdoor key and page controls.
// Assumes an APB master on pclk and a reset-time option load port.
//
// Overview of operation
// - Divisor-written flag clears at reset, sets on first divider write.
// - Erase and program blocked until the divisor-written flag is set.
// - Prescale bit write-once; one divides bus clock by eight.
// - Timing clock is prescaled bus clock divided by divisor plus one.
// - Each program or erase pulse is one timing clock period.
// - Option mirror loads from stored option byte on every reset.
// - With backdoor allowed, eight matching key bytes unsecure until reset.
// - Key writes from the debug port are ignored.
// - Option bit 6 one disables vector redirection.
// - Sector layout bit selects two 4-byte pages or one 8-byte page.
// - Security code 1:0 alone means unsecured.
// - While secured, unsecured sources cannot reach memory contents.
// - Security code becomes 1:0 after key unlock or blank check.
// - Page choice bit maps page 1 or page 0; other hidden.
// - Arm bit steers 0xffb0-0xffb7 writes to key or command start.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module nvcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] stored_option_byte,
  input wire logic [63:0] stored_unlock_key,
  input wire nvcs_pkg::nvcs_cpu_wr_t cpu_wr,
  input wire logic blank_check_ok,
  input wire logic access_unsecured_src,
  input wire logic nv_op_busy,
  output logic access_grant,
  output logic nv_timing_clock,
  output logic nv_pulse,
  output nvcs_pkg::nvcs_ctl_t ctl
);
  import nvcs_pkg::*;

  logic [7:0] div_reg_r;
  logic div_written_r;
  logic [7:0] opt_r;
  logic opt_loaded_r;
  logic [7:0] cfg_r;
  logic unlock_r;
  logic [2:0] key_idx_r;
  logic key_ok_r;
  logic [7:0] key_rdata;
  logic key_chk_r;
  logic [2:0] key_chk_idx_r;
  logic [7:0] key_chk_data_r;
  logic key_cmp_r;
  logic [2:0] key_cmp_idx_r;
  logic [7:0] key_cmp_data_r;
  logic apb_wr;
  logic key_hit;
  logic key_wr;
  logic secured;
  logic tick;

  function automatic logic code_is_secure(input logic [1:0] code);
    // Only 1:0 is open; every other code locks
    code_is_secure = (code != NVCS_PROT_OPEN);
  endfunction

  function automatic logic in_key_window(input logic [15:0] a);
    in_key_window = (a[15:3] == NVCS_KEY_BASE[15:3]);
  endfunction

  // APB: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        NVCS_DIV_OFS, NVCS_OPT_OFS, NVCS_CFG_OFS, NVCS_STAT_OFS:
          pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  // Divider register: DIV always writable, prescale bit write-once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg_r <= NVCS_DIV_RST;
      div_written_r <= 1'b0;
    end else if (apb_wr && paddr == NVCS_DIV_OFS) begin
      div_written_r <= 1'b1;
      div_reg_r[NVCS_DIV_MSB:0] <= pwdata[NVCS_DIV_MSB:0];
      if (!div_written_r) begin
        div_reg_r[NVCS_PRE8_BIT] <= pwdata[NVCS_PRE8_BIT];
      end
    end
  end

  // Option mirror: reset gives a constant; load on first clock after
  // release, since the async reset may not sample a port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_r <= 8'h00;
      opt_loaded_r <= 1'b0;
    end else if (!opt_loaded_r) begin
      opt_r <= stored_option_byte;
      opt_loaded_r <= 1'b1;
    end
  end

  // Config register: page choice and key arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= NVCS_CFG_RST;
    end else if (apb_wr && paddr == NVCS_CFG_OFS) begin
      cfg_r[NVCS_PAGE_BIT] <= pwdata[NVCS_PAGE_BIT];
      cfg_r[NVCS_ARM_BIT] <= pwdata[NVCS_ARM_BIT];
    end
  end

  // Key window writes from firmware only when armed
  assign key_hit = cpu_wr.valid && in_key_window(cpu_wr.addr);
  assign key_wr = key_hit && cfg_r[NVCS_ARM_BIT] && !cpu_wr.from_debug
    && opt_r[NVCS_ALLOW_BIT];

  nvcs_keymem u_keymem (
    .pclk(pclk),
    .presetn(presetn),
    .wr(key_wr),
    .waddr(cpu_wr.addr[2:0]),
    .wdata(cpu_wr.data),
    .raddr(key_chk_idx_r),
    .rdata(key_rdata)
  );

  // Sequence tracking: bytes must arrive in order 0..7
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_idx_r <= 3'h0;
      key_ok_r <= 1'b1;
      key_chk_r <= 1'b0;
      key_chk_idx_r <= 3'h0;
      key_chk_data_r <= 8'h00;
      key_cmp_r <= 1'b0;
      key_cmp_idx_r <= 3'h0;
      key_cmp_data_r <= 8'h00;
    end else begin
      key_chk_r <= key_wr;
      // Stored byte reads out a cycle after it lands; compare then
      key_cmp_r <= key_chk_r;
      key_cmp_idx_r <= key_chk_idx_r;
      key_cmp_data_r <= key_chk_data_r;
      if (key_wr) begin
        key_chk_idx_r <= cpu_wr.addr[2:0];
        key_chk_data_r <= stored_unlock_key[
          {3'h7 - cpu_wr.addr[2:0], 3'h0} +: 8];
        if (cpu_wr.addr[2:0] != key_idx_r) begin
          key_ok_r <= 1'b0;
        end
        key_idx_r <= (cpu_wr.addr[2:0] == 3'h7) ? 3'h0
          : key_idx_r + 3'h1;
      end
      if (key_cmp_r) begin
        // Restart a fresh attempt after the last byte is checked
        if (key_cmp_idx_r == 3'h7) begin
          key_ok_r <= 1'b1;
        end else if (key_rdata != key_cmp_data_r) begin
          key_ok_r <= 1'b0;
        end
      end
    end
  end

  // Unlock holds until next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= 1'b0;
    end else if (blank_check_ok) begin
      unlock_r <= 1'b1;
    end else if (key_cmp_r && key_cmp_idx_r == 3'h7 && key_ok_r
      && key_rdata == key_cmp_data_r && opt_r[NVCS_ALLOW_BIT]) begin
      unlock_r <= 1'b1;
    end
  end

  // Effective code reads 1:0 once unlocked
  assign secured = unlock_r ? 1'b0
    : code_is_secure(opt_r[NVCS_PROT_MSB:0]);

  // Deny memory contents to unsecured sources while locked
  assign access_grant = !(secured && access_unsecured_src);

  // Timing clock runs only once the divisor is loaded
  nvcs_clkdiv u_clkdiv (
    .pclk(pclk),
    .presetn(presetn),
    .run(div_written_r),
    .prescale_by_eight(div_reg_r[NVCS_PRE8_BIT]),
    .div(div_reg_r[NVCS_DIV_MSB:0]),
    .nv_timing_clock(tick)
  );
  assign nv_timing_clock = tick;

  // Pulse spans tick to tick, one timing period; a started pulse
  // always runs to its end so the sequencer counts whole pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_pulse <= 1'b0;
    end else if (!div_written_r) begin
      nv_pulse <= 1'b0;
    end else if (tick) begin
      nv_pulse <= !nv_pulse && nv_op_busy;
    end
  end

  // Control outputs registered, data outputs from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= '0;
    end else begin
      ctl.nv_write_ok <= div_written_r;
      ctl.key_write <= key_wr;
      // Command start blocked until divisor written
      ctl.cmd_start <= key_hit && !cfg_r[NVCS_ARM_BIT] && div_written_r;
      ctl.page_sel <= cfg_r[NVCS_PAGE_BIT];
      ctl.sector_layout <= opt_r[NVCS_LAYOUT_BIT];
      ctl.redirect_en <= !opt_r[NVCS_NORED_BIT];
      ctl.secured <= secured;
    end
  end

  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        NVCS_DIV_OFS:
          prdata <= {24'h0, div_written_r, div_reg_r[6:0]};
        NVCS_OPT_OFS: prdata <= {24'h0, opt_r};
        NVCS_CFG_OFS: prdata <= {24'h0, cfg_r};
        NVCS_STAT_OFS:
          prdata <= {29'h0, unlock_r, secured, div_written_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verilog/nvcs_pkg.sv
// Package for the nonvolatile configuration and security block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package nvcs_pkg;
  // Register byte offsets
  localparam logic [7:0] NVCS_DIV_OFS = 8'h00;
  localparam logic [7:0] NVCS_OPT_OFS = 8'h04;
  localparam logic [7:0] NVCS_CFG_OFS = 8'h08;
  localparam logic [7:0] NVCS_STAT_OFS = 8'h0c;
  // Clock divider register fields
  localparam int NVCS_WRITTEN_BIT = 7;
  localparam int NVCS_PRE8_BIT = 6;
  localparam int NVCS_DIV_MSB = 5;
  // Option byte fields
  localparam int NVCS_ALLOW_BIT = 7;
  localparam int NVCS_NORED_BIT = 6;
  localparam int NVCS_LAYOUT_BIT = 5;
  localparam int NVCS_PROT_MSB = 1;
  // Config register fields
  localparam int NVCS_PAGE_BIT = 6;
  localparam int NVCS_ARM_BIT = 5;
  // Reset values and the open security code
  localparam logic [7:0] NVCS_DIV_RST = 8'h00;
  localparam logic [7:0] NVCS_CFG_RST = 8'h00;
  localparam logic [1:0] NVCS_PROT_OPEN = 2'h2;
  // Prescaler
  localparam logic [2:0] NVCS_PRE8_LAST = 3'h7;
  // Backdoor key window in the CPU map
  localparam logic [15:0] NVCS_KEY_BASE = 16'hffb0;
  localparam int NVCS_KEY_BYTES = 8;
  // Timing clock limits, kHz, and bus clock
  localparam int NVCS_TCLK_MIN_KHZ = 150;
  localparam int NVCS_TCLK_MAX_KHZ = 200;
  localparam int NVCS_BUS_KHZ = 40000;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
    logic from_debug;
  } nvcs_cpu_wr_t;

  typedef struct packed {
    logic nv_write_ok;
    logic key_write;
    logic cmd_start;
    logic page_sel;
    logic sector_layout;
    logic redirect_en;
    logic secured;
  } nvcs_ctl_t;
endpackage

// ===== verilog/nvcs_clkdiv.sv
// Timing-clock enable generator: bus clock, optional /8, then /(div+1).
// Assumes one clock; output is a one-cycle enable, not a clock net.
`timescale 1ns/100ps
`default_nettype none
module nvcs_clkdiv (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic prescale_by_eight,
  input wire logic [5:0] div,
  output logic nv_timing_clock
);
  import nvcs_pkg::*;

  logic [2:0] pre_r;
  logic [5:0] cnt_r;
  logic pre_tick;

  // Prescaler yields one enable per eight bus cycles when prescale_by_eight is set, else one every bus cycle
  assign pre_tick = prescale_by_eight ? (pre_r == NVCS_PRE8_LAST) : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 3'h0;
    end else if (!run) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  // Reloadable down-counter, one pulse per div+1 ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 6'h00;
      nv_timing_clock <= 1'b0;
    end else if (!run) begin
      cnt_r <= div;
      nv_timing_clock <= 1'b0;
    end else begin
      nv_timing_clock <= 1'b0;
      if (pre_tick) begin
        if (cnt_r == 6'h00) begin
          cnt_r <= div;
          nv_timing_clock <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 6'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/nvcs_keymem.sv
// Eight-byte key compare store with registered read data.
// Assumes byte index and data arrive with a write strobe.
`timescale 1ns/100ps
`default_nettype none
module nvcs_keymem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [2:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] raddr,
  output logic [7:0] rdata
);
  import nvcs_pkg::*;

  logic [7:0] mem_r [NVCS_KEY_BYTES];

  genvar g;
  generate
    for (g = 0; g < NVCS_KEY_BYTES; g++) begin : g_byte
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_r[g] <= 8'h00;
        end else if (wr && (waddr == 3'(g))) begin
          mem_r[g] <= wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_r[raddr];
    end
  end
endmodule
`default_nettype wire

// ===== sim/nvcs_top_props.sv
// Property checker for the nonvolatile configuration block.
// Sees only the top-level ports; bound into nvcs_top below.
`timescale 1ns/100ps
`default_nettype none
module nvcs_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire nvcs_pkg::nvcs_cpu_wr_t cpu_wr,
  input wire logic access_unsecured_src,
  input wire logic nv_op_busy,
  input wire logic access_grant,
  input wire logic nv_pulse,
  input wire logic nv_timing_clock,
  input wire nvcs_pkg::nvcs_ctl_t ctl
);
  import nvcs_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire wr_any = psel && penable && pwrite;
  wire wr_div = wr_any && paddr == NVCS_DIV_OFS;
  wire wr_cfg = wr_any && paddr == NVCS_CFG_OFS;
  property p_div_set;
    wr_div |-> ##2 ctl.nv_write_ok;
  endproperty
  a_div_set: assert property (p_div_set)
    else $error("divisor flag not set");
  property p_div_keep;
    ctl.nv_write_ok |=> ctl.nv_write_ok;
  endproperty
  a_div_keep: assert property (p_div_keep)
    else $error("divisor flag dropped");
  property p_gate;
    nv_pulse |-> ctl.nv_write_ok;
  endproperty
  a_gate: assert property (p_gate)
    else $error("pulse before divider write");
  // Edges only on timing ticks, so each pulse spans one period
  property p_hold;
    $changed(nv_pulse) |-> $past(nv_timing_clock);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pulse edge off tick");
  property p_start;
    $rose(nv_pulse) |-> $past(nv_op_busy);
  endproperty
  a_start: assert property (p_start)
    else $error("pulse without busy");
  // Local copy: a later write must not disturb the check
  property p_page;
    logic b;
    (wr_cfg, b = pwdata[NVCS_PAGE_BIT]) |-> ##2 ctl.page_sel == b;
  endproperty
  a_page: assert property (p_page)
    else $error("page choice wrong");
  property p_src;
    ctl.key_write |-> $past(cpu_wr.valid) && !$past(cpu_wr.from_debug);
  endproperty
  a_src: assert property (p_src)
    else $error("key write without user source");
  property p_steer;
    !(ctl.key_write && ctl.cmd_start);
  endproperty
  a_steer: assert property (p_steer)
    else $error("key and command together");
  property p_deny;
    access_unsecured_src ##1 ctl.secured |-> !$past(access_grant);
  endproperty
  a_deny: assert property (p_deny)
    else $error("secured access granted");
  c_unlock: cover property ($fell(ctl.secured));
  c_key: cover property (ctl.key_write);
  c_cmd: cover property (ctl.cmd_start);
  c_pulse: cover property ($rose(nv_pulse));
endmodule
bind nvcs_top nvcs_top_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .cpu_wr(cpu_wr),
  .access_unsecured_src(access_unsecured_src),
  .nv_op_busy(nv_op_busy),
  .access_grant(access_grant),
  .nv_pulse(nv_pulse),
  .nv_timing_clock(nv_timing_clock),
  .ctl(ctl)
);
`default_nettype wire

// ===== sim/nvcs_top_bench.sv
// Self-checking bench for the nonvolatile configuration block.
// Drives every input itself; no far-side model.
`timescale 1ns/100ps
`default_nettype none
module nvcs_top_bench;
  import nvcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, pre;
  logic [7:0] paddr, stored_option_byte, opt;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] stored_unlock_key;
  logic blank_check_ok, access_unsecured_src, nv_op_busy, access_grant;
  logic nv_timing_clock, nv_pulse;
  logic [5:0] dv;
  nvcs_cpu_wr_t cpu_wr;
  nvcs_ctl_t ctl;
  int n_mismatch, n_checks, seed, g;
  int nkey = 0;
  int ncmd = 0;
  nvcs_top u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .stored_option_byte(stored_option_byte),
    .stored_unlock_key(stored_unlock_key),
    .cpu_wr(cpu_wr),
    .blank_check_ok(blank_check_ok),
    .access_unsecured_src(access_unsecured_src),
    .nv_op_busy(nv_op_busy),
    .access_grant(access_grant),
    .nv_timing_clock(nv_timing_clock),
    .nv_pulse(nv_pulse),
    .ctl(ctl)
  );
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Counted on the falling edge, clear of register updates
  always @(negedge pclk) begin
    nkey <= nkey + int'(ctl.key_write === 1'b1);
    ncmd <= ncmd + int'(ctl.cmd_start === 1'b1);
  end
  function automatic int per(logic p, logic [5:0] d);
    return (p ? 8 : 1) * (int'(d) + 1);
  endfunction
  function automatic logic prot_of(logic [7:0] o);
    return o[NVCS_PROT_MSB:0] !== NVCS_PROT_OPEN;
  endfunction
  task final_report;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      n_mismatch++;
      final_report;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rst(input logic [7:0] o);
    presetn <= 1'b0;
    stored_option_byte <= o;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  task prot(input logic s);
    @(negedge pclk);
    chk(ctl.secured, s);
    chk(access_grant, !s);
    @(posedge pclk);
  endtask
  // Valid held high across all eight bytes: back-to-back case
  task keyseq(input logic [63:0] k, input logic dbg);
    for (int i = 0; i < 8; i++) begin
      cpu_wr <= '{1'b1, NVCS_KEY_BASE + 16'(i), k[63-8*i -: 8], dbg};
      @(posedge pclk);
    end
    cpu_wr.valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // First pulse may follow a reload, so the second gap is measured
  task gap(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (nv_timing_clock !== 1'b1 && n < 1000);
    if (n < 1000) n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (nv_timing_clock !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      n_mismatch++;
      final_report;
    end
    @(posedge pclk);
  endtask
  // Width of the next sequencer pulse, in cycles
  task pw(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (nv_pulse !== 1'b1 && n < 1200);
    if (n < 1200) n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (nv_pulse === 1'b1 && n < 1200);
    if (n >= 1200) begin
      n_mismatch++;
      final_report;
    end
    @(posedge pclk);
  endtask
  initial begin
    seed = 74955;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, cpu_wr} = '0;
    {blank_check_ok, nv_op_busy, stored_option_byte} = '0;
    access_unsecured_src = 1'b1;
    stored_unlock_key = {$random(seed), $random(seed)};
    @(posedge pclk);
    for (int c = 0; c < 4; c++) begin
      opt = 8'($random(seed)) & 8'hfc | 8'(c);
      rst(opt);
      apb(1'b0, NVCS_OPT_OFS, 32'h0);
      chk(rd, {24'h0, opt});
      chk(err, 1'b0);
      apb(1'b0, NVCS_DIV_OFS, 32'h0);
      chk(rd, 32'h0);
      prot(prot_of(opt));
      chk(ctl.redirect_en, !opt[NVCS_NORED_BIT]);
      chk(ctl.sector_layout, opt[NVCS_LAYOUT_BIT]);
    end
    $display("option decode test done");
    for (int i = 0; i < 3; i++) begin
      // Last round keeps the timing clock within its band
      pre = i == 0 ? 1'b0 : 1'b1;
      dv = i == 0 ? 6'h3f : i == 1 ? 6'h00
        : ~6'(24 + ($random(seed) & 7));
      rst(8'h80);
      nv_op_busy <= 1'b1;
      repeat (40) @(posedge pclk);
      chk(nv_pulse, 1'b0);
      apb(1'b1, NVCS_DIV_OFS, {25'h0, pre, dv});
      apb(1'b1, NVCS_DIV_OFS, {25'h0, !pre, ~dv});
      apb(1'b0, NVCS_DIV_OFS, 32'h0);
      chk(rd, {24'h0, 1'b1, pre, ~dv});
      gap(g);
      chk(g, per(pre, ~dv));
      pw(g);
      chk(g, per(pre, ~dv));
      nv_op_busy <= 1'b0;
      repeat (per(pre, ~dv) + 2) @(posedge pclk);
      chk(nv_pulse, 1'b0);
    end
    $display("divider test done");
    rst(8'h80);
    apb(1'b1, NVCS_DIV_OFS, 32'h0);
    apb(1'b1, NVCS_CFG_OFS, 32'h60);
    apb(1'b0, NVCS_CFG_OFS, 32'h0);
    chk(rd, 32'h60);
    chk(ctl.page_sel, 1'b1);
    keyseq(stored_unlock_key, 1'b1);
    chk(nkey, 0);
    prot(1'b1);
    keyseq(stored_unlock_key ^ 64'h1, 1'b0);
    prot(1'b1);
    keyseq(stored_unlock_key, 1'b0);
    prot(1'b0);
    chk(nkey, 16);
    apb(1'b1, NVCS_CFG_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    chk(ctl.page_sel, 1'b0);
    keyseq(stored_unlock_key, 1'b0);
    chk(nkey, 16);
    chk(ncmd != 0, 1'b1);
    rst(8'h00);
    apb(1'b1, NVCS_CFG_OFS, 32'h20);
    keyseq(stored_unlock_key, 1'b0);
    prot(1'b1);
    blank_check_ok <= 1'b1;
    @(posedge pclk);
    blank_check_ok <= 1'b0;
    repeat (2) @(posedge pclk);
    prot(1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    $display("key and unlock test done");
    final_report;
  end
endmodule
`default_nettype wire
